// ===== pptb_pkg.sv
package pptb_pkg;
    localparam int NUM_ENTRIES = 64;
    localparam int IDX_W = 6;
    localparam int FETCH_ENTRIES = 4;
    localparam int MASK_W = 12;
    localparam int VIRTUAL_PAGE_PAIR_NUMBER_W = 31;
    localparam int REGION_W = 2;
    localparam int TAG_W = 8;
    localparam int UC_W = 2;
    localparam int FRAME_W = 28;
    localparam int ALG_W = 3;
    localparam int VA_W = 64;
    localparam int XLATE_W = 44;
    localparam int PA_W = 40;
    localparam int MIN_OFS = 12;
    localparam int VIRTUAL_PAGE_PAIR_NUMBER_LSB = 13;
    localparam int REGION_HI = 63;
    localparam int REGION_LO = 62;
    localparam logic [TAG_W-1:0] TAG_RST = 8'h00;

    typedef struct packed {
        logic [UC_W-1:0] uncached_attribute;
        logic [FRAME_W-1:0] frame_number;
        logic [ALG_W-1:0] alg;
        logic dirty;
        logic valid;
    } pptb_page_t;

    typedef struct packed {
        logic [MASK_W-1:0] mask;
        logic [REGION_W-1:0] region;
        logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] virtual_page_pair_number;
        logic global_bit;
        logic [TAG_W-1:0] space_tag;
        pptb_page_t even_page;
        pptb_page_t odd_page;
    } pptb_entry_t;

    typedef struct packed {
        logic hit;
        logic miss;
        logic fault;
        logic [PA_W-1:0] paddr;
        logic [ALG_W-1:0] alg;
        logic [UC_W-1:0] uncached_attribute;
    } pptb_result_t;
endpackage

// ===== pptb_buffer.sv
`timescale 1ns/10ps
// Function
// - Missing translation raises miss; invalid page raises fault
// - Sixty-four entries each mapping page pair
// - Entry holds mask, pair number, region, global, tag
// - Each page half holds attribute, frame, flags
// - Translate low 44 bits; offset passes
// - Bits 63:62 matched against region selector
// - Bits 61:44 never stored nor compared
// - Joint buffer translates data addresses
// - Fetch buffer first; refill from joint
// - Fetch buffer invisible to software
// - Current tag in high staging low byte
// - Written entry takes tag from staging
// - Participates if tag equal or global
// - Compare tags only on staging write
// - Writing entry sets its enable latch
// - Global bit enables regardless of tag
// - Conflict flag on multiple match write
// - Invalidate conflicting entries in the writing cycle
// - Page sizes 4 Kbytes to 16 Mbytes
// - Lowest page bit selects page half
module pptb_buffer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic data_req,
    input wire logic [63:0] data_vaddr,
    input wire logic data_store,
    input wire logic fetch_req,
    input wire logic [63:0] fetch_vaddr,
    input wire logic high_staging_we,
    input wire logic [63:0] high_staging_wdata,
    input wire logic entry_we,
    input wire logic [5:0] entry_index,
    input wire logic [11:0] page_size_staging_reg,
    input wire logic [63:0] even_page_staging_reg,
    input wire logic [63:0] odd_page_staging_reg,
    output pptb_pkg::pptb_result_t data_result,
    output pptb_pkg::pptb_result_t fetch_result,
    output logic [63:0] entry_high_staging_reg,
    output logic conflict_status_flag
);
    pptb_pkg::pptb_entry_t ent_r [pptb_pkg::NUM_ENTRIES];
    logic [pptb_pkg::NUM_ENTRIES-1:0] en_r, en_nxt, live_r, live_nxt;
    logic [63:0] hi_r, hi_nxt;
    logic conf_r, conf_nxt;
    pptb_pkg::pptb_result_t dres_r, dres_nxt, fres_r, fres_nxt;
    pptb_pkg::pptb_entry_t fent_r [pptb_pkg::FETCH_ENTRIES];
    logic [pptb_pkg::FETCH_ENTRIES-1:0] fval_r, fval_nxt;
    logic [1:0] fptr_r, fptr_nxt;
    pptb_pkg::pptb_entry_t new_ent;
    logic [pptb_pkg::NUM_ENTRIES-1:0] conf_vec;

    // Pair match ignoring offset bits and the half-select bit; bits 61:44 are not looked at.
    function automatic logic va_match(input pptb_pkg::pptb_entry_t e, input logic [63:0] va);
        logic [pptb_pkg::VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] m;
        m = {19'h00000, e.mask};
        va_match = (e.region == va[pptb_pkg::REGION_HI:pptb_pkg::REGION_LO]) &&
            (((e.virtual_page_pair_number ^ va[pptb_pkg::XLATE_W-1:pptb_pkg::VIRTUAL_PAGE_PAIR_NUMBER_LSB])
            & ~m) == '0);
    endfunction

    // Lowest page bit picks the half; mask is thermometer-coded from bit 12 up.
    function automatic pptb_pkg::pptb_page_t pick(input pptb_pkg::pptb_entry_t e,
                                                  input logic [63:0] va);
        logic [5:0] sh;
        sh = 6'h0c;
        for (int i = 0; i < pptb_pkg::MASK_W; i++) begin
            if (e.mask[i]) begin
                sh = 6'(pptb_pkg::MIN_OFS + i + 1);
            end
        end
        pick = va[sh] ? e.odd_page : e.even_page;
    endfunction

    function automatic pptb_pkg::pptb_result_t build(input pptb_pkg::pptb_entry_t e,
                                                     input logic [63:0] va,
                                                     input logic st);
        pptb_pkg::pptb_page_t p;
        logic [39:0] fr, om;
        p = pick(e, va);
        om = {16'h0000, e.mask, 12'hfff};
        fr = {p.frame_number, 12'h000};
        build.hit = p.valid && !(st && !p.dirty);
        build.miss = 1'b0;
        build.fault = !build.hit;
        build.paddr = (fr & ~om) | (va[39:0] & om);
        build.alg = p.alg;
        build.uncached_attribute = p.uncached_attribute;
    endfunction

    always_comb begin
        new_ent.mask = page_size_staging_reg;
        new_ent.region = hi_r[pptb_pkg::REGION_HI:pptb_pkg::REGION_LO];
        new_ent.virtual_page_pair_number = hi_r[pptb_pkg::XLATE_W-1:pptb_pkg::VIRTUAL_PAGE_PAIR_NUMBER_LSB];
        new_ent.global_bit = even_page_staging_reg[0] & odd_page_staging_reg[0];
        new_ent.space_tag = hi_r[pptb_pkg::TAG_W-1:0];
        new_ent.even_page = {even_page_staging_reg[63:62], even_page_staging_reg[33:1]};
        new_ent.odd_page = {odd_page_staging_reg[63:62], odd_page_staging_reg[33:1]};
        for (int i = 0; i < pptb_pkg::NUM_ENTRIES; i++) begin
            conf_vec[i] = live_r[i] && (i != int'(entry_index)) &&
                (va_match(ent_r[i], {hi_r[63:13], 13'h0000}) ||
                 va_match(new_ent, {ent_r[i].region, 18'h00000,
                                    ent_r[i].virtual_page_pair_number, 13'h0000}));
        end
    end

    always_comb begin
        hi_nxt = hi_r;
        en_nxt = en_r;
        live_nxt = live_r;
        conf_nxt = conf_r;
        if (high_staging_we) begin
            hi_nxt = high_staging_wdata;
            for (int i = 0; i < pptb_pkg::NUM_ENTRIES; i++) begin
                en_nxt[i] = ent_r[i].global_bit ||
                    (ent_r[i].space_tag == high_staging_wdata[pptb_pkg::TAG_W-1:0]);
            end
        end
        if (entry_we) begin
            conf_nxt = $countones(conf_vec) > 1;
            live_nxt = live_nxt & ~conf_vec;
            live_nxt[entry_index] = 1'b1;
            en_nxt[entry_index] = 1'b1;
        end
    end

    always_comb begin
        dres_nxt = '0;
        dres_nxt.miss = data_req;
        for (int i = 0; i < pptb_pkg::NUM_ENTRIES; i++) begin
            if (data_req && live_r[i] && en_r[i] && va_match(ent_r[i], data_vaddr)) begin
                dres_nxt = build(ent_r[i], data_vaddr, data_store);
            end
        end
    end

    // The fetch buffer is flushed on any write so it never holds stale translations.
    always_comb begin
        logic fhit;
        fhit = 1'b0;
        fres_nxt = '0;
        fval_nxt = (entry_we || high_staging_we) ? '0 : fval_r;
        fptr_nxt = fptr_r;
        for (int i = 0; i < pptb_pkg::FETCH_ENTRIES; i++) begin
            if (fetch_req && fval_r[i] && va_match(fent_r[i], fetch_vaddr)) begin
                fres_nxt = build(fent_r[i], fetch_vaddr, 1'b0);
                fhit = 1'b1;
            end
        end
        if (fetch_req && !fhit) begin
            fres_nxt.miss = 1'b1;
            for (int i = 0; i < pptb_pkg::NUM_ENTRIES; i++) begin
                if (live_r[i] && en_r[i] && va_match(ent_r[i], fetch_vaddr)) begin
                    fres_nxt = build(ent_r[i], fetch_vaddr, 1'b0);
                end
            end
            if (!fres_nxt.miss && !(entry_we || high_staging_we)) begin
                fval_nxt[fptr_r] = 1'b1;
                fptr_nxt = fptr_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hi_r <= {56'h0, pptb_pkg::TAG_RST};
            en_r <= '0;
            live_r <= '0;
            conf_r <= 1'b0;
            dres_r <= '0;
            fres_r <= '0;
            fval_r <= '0;
            fptr_r <= 2'h0;
        end else begin
            hi_r <= hi_nxt;
            en_r <= en_nxt;
            live_r <= live_nxt;
            conf_r <= conf_nxt;
            dres_r <= dres_nxt;
            fres_r <= fres_nxt;
            fval_r <= fval_nxt;
            fptr_r <= fptr_nxt;
        end
    end

    // Entry storage carries no reset; the live bits guard it.
    always_ff @(posedge clk) begin
        if (entry_we) begin
            ent_r[entry_index] <= new_ent;
        end
        for (int i = 0; i < pptb_pkg::FETCH_ENTRIES; i++) begin
            if (fetch_req && fval_nxt[i] && !fval_r[i]) begin
                for (int j = 0; j < pptb_pkg::NUM_ENTRIES; j++) begin
                    if (live_r[j] && en_r[j] && va_match(ent_r[j], fetch_vaddr)) begin
                        fent_r[i] <= ent_r[j];
                    end
                end
            end
        end
    end

    assign data_result = dres_r;
    assign fetch_result = fres_r;
    assign entry_high_staging_reg = hi_r;
    assign conflict_status_flag = conf_r;

    // The checks below watch registered state, so each implication looks one edge after its cause.
    // The reset check carries no disable clause because it is about reset itself.
    AST_RESET_QUIET: assert property (@(posedge clk)
        sys_rst |=> (live_r == '0) && !conflict_status_flag)
        else $error("state left after reset");

    AST_ENTRY_ENABLED: assert property (@(posedge clk) disable iff (sys_rst)
        entry_we |=> en_r[$past(entry_index)])
        else $error("written entry not enabled");

    AST_LIVE_WRITTEN: assert property (@(posedge clk) disable iff (sys_rst)
        entry_we |=> live_r[$past(entry_index)])
        else $error("written entry not live");

    AST_CONFLICT: assert property (@(posedge clk) disable iff (sys_rst)
        entry_we && ($countones(conf_vec) > 1) |=> conflict_status_flag)
        else $error("conflict flag not set");

    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        !entry_we |=> $stable(conflict_status_flag))
        else $error("conflict flag moved without write");

    AST_INVALIDATE: assert property (@(posedge clk) disable iff (sys_rst)
        entry_we |=> ((live_r & $past(conf_vec)) == '0))
        else $error("conflicting entry still live");

    AST_TAG_HELD: assert property (@(posedge clk) disable iff (sys_rst)
        high_staging_we |=> entry_high_staging_reg[7:0] == $past(high_staging_wdata[7:0]))
        else $error("tag not held");

    AST_STAGING_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        !high_staging_we |=> $stable(entry_high_staging_reg))
        else $error("staging changed without write");

    AST_ENABLE_STATIC: assert property (@(posedge clk) disable iff (sys_rst)
        !high_staging_we && !entry_we |=> en_r == $past(en_r))
        else $error("enable changed without write");

    AST_DATA_MISS: assert property (@(posedge clk) disable iff (sys_rst)
        data_req && (live_r & en_r) == '0 |=> data_result.miss)
        else $error("miss not raised");

    AST_NO_TAG_HIT: assert property (@(posedge clk) disable iff (sys_rst)
        data_req && (live_r & en_r) == '0 |=> !data_result.hit)
        else $error("hit without enabled entry");

    AST_DATA_ANSWER: assert property (@(posedge clk) disable iff (sys_rst)
        data_req |=> data_result.hit || data_result.miss || data_result.fault)
        else $error("data request unanswered");

    AST_NO_REQ_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
        !data_req |=> !data_result.hit && !data_result.miss)
        else $error("result without request");

    AST_DATA_ONEHOT: assert property (@(posedge clk) disable iff (sys_rst)
        $onehot0({data_result.hit, data_result.miss, data_result.fault}))
        else $error("data result flags overlap");

    AST_FAULT_EXCL: assert property (@(posedge clk) disable iff (sys_rst)
        !(fetch_result.hit && fetch_result.fault))
        else $error("hit and fault together");

    AST_FETCH_ONEHOT: assert property (@(posedge clk) disable iff (sys_rst)
        $onehot0({fetch_result.hit, fetch_result.miss, fetch_result.fault}))
        else $error("fetch result flags overlap");

    AST_OFFSET_PASS: assert property (@(posedge clk) disable iff (sys_rst)
        data_req |=> !data_result.hit || data_result.paddr[11:0] == $past(data_vaddr[11:0]))
        else $error("data offset altered");

    AST_FETCH_OFFSET: assert property (@(posedge clk) disable iff (sys_rst)
        fetch_req |=> !fetch_result.hit || fetch_result.paddr[11:0] == $past(fetch_vaddr[11:0]))
        else $error("fetch offset altered");

    AST_FETCH_MISS: assert property (@(posedge clk) disable iff (sys_rst)
        fetch_req && fval_r == '0 && (live_r & en_r) == '0 |=> fetch_result.miss)
        else $error("fetch miss not raised");

    AST_FETCH_ANSWER: assert property (@(posedge clk) disable iff (sys_rst)
        fetch_req |=> fetch_result.hit || fetch_result.miss || fetch_result.fault)
        else $error("fetch request unanswered");

    AST_FETCH_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
        !fetch_req |=> !fetch_result.hit && !fetch_result.miss && !fetch_result.fault)
        else $error("fetch result without request");

    AST_FLUSH: assert property (@(posedge clk) disable iff (sys_rst)
        entry_we || high_staging_we |=> fval_r == '0)
        else $error("fetch buffer kept across write");
endmodule

// ===== pptb_pipe.sv
`timescale 1ns/10ps
// Pipeline side of the buffer: one lookup per call, held for exactly one cycle.
module pptb_pipe (
    input wire logic clk,
    output logic data_req,
    output logic [63:0] data_vaddr,
    output logic data_store,
    output logic fetch_req,
    output logic [63:0] fetch_vaddr
);
    initial begin
        data_req = 1'b0;
        fetch_req = 1'b0;
        data_store = 1'b0;
        data_vaddr = 64'h0;
        fetch_vaddr = 64'h0;
    end
    // Idle address lines are inverted so that a stale address never passes for a live one.
    task automatic look(input bit f, input logic [63:0] va, input logic st);
        logic [63:0] a;
        a = {va[63:62], {18{va[61]}}, va[43:0]};
        @(negedge clk);
        data_req = !f;
        fetch_req = f;
        data_store = st;
        if (f) fetch_vaddr = a;
        else data_vaddr = a;
        @(negedge clk);
        data_req = 1'b0;
        fetch_req = 1'b0;
        data_vaddr = ~data_vaddr;
        fetch_vaddr = ~fetch_vaddr;
    endtask
endmodule

// ===== pptb_buffer_bench.sv
`timescale 1ns/10ps
module pptb_buffer_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic data_req, data_store, fetch_req, flag, hwe = 1'b0, ewe = 1'b0;
    logic [63:0] dva, fva, shi, a, b, hwd = 64'h0, ev = 64'h0, od = 64'h0;
    logic [5:0] idx = 6'h00;
    logic [11:0] msk = 12'h000;
    pptb_pkg::pptb_result_t dres, fres, r;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    always #2 clk = ~clk;
    pptb_pipe u_pipe (.clk(clk), .data_req(data_req), .data_vaddr(dva),
        .data_store(data_store), .fetch_req(fetch_req), .fetch_vaddr(fva));
    pptb_buffer u_dut (.clk(clk), .sys_rst(sys_rst), .data_req(data_req), .data_vaddr(dva),
        .data_store(data_store), .fetch_req(fetch_req), .fetch_vaddr(fva),
        .high_staging_we(hwe), .high_staging_wdata(hwd), .entry_we(ewe), .entry_index(idx),
        .page_size_staging_reg(msk), .even_page_staging_reg(ev), .odd_page_staging_reg(od),
        .data_result(dres), .fetch_result(fres), .entry_high_staging_reg(shi),
        .conflict_status_flag(flag));
    task automatic summarize();
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // The whole run needs well under a thousand cycles; a hang is cut off far beyond that.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic chk(input pptb_pkg::pptb_result_t g, input pptb_pkg::pptb_result_t e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk64(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rst();
        sys_rst = 1'b1;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
    endtask
    task automatic whi(input logic [63:0] d);
        @(negedge clk);
        hwe = 1'b1;
        hwd = d;
        @(negedge clk);
        hwe = 1'b0;
    endtask
    task automatic went(input logic [5:0] k, input logic [11:0] m);
        @(negedge clk);
        ewe = 1'b1;
        idx = k;
        msk = m;
        @(negedge clk);
        ewe = 1'b0;
    endtask
    task automatic lk(input bit f, input logic [63:0] va, input logic st);
        u_pipe.look(f, va, st);
        r = f ? fres : dres;
    endtask
    function automatic logic [63:0] hi(input logic [1:0] g, input logic [30:0] v,
        input logic [7:0] t);
        return {g, 18'h0, v, 5'h0, t};
    endfunction
    function automatic logic [63:0] lo(input logic [1:0] u, input logic [27:0] f,
        input logic [2:0] c, input logic d, input logic v);
        return {u, 28'h0, f, c, d, v, 1'b0};
    endfunction
    function automatic logic [63:0] mkva(input logic [1:0] g, input logic [30:0] v,
        input int o, input bit h, input logic [23:0] off);
        logic [63:0] x, om;
        om = (64'h1 << o) - 64'h1;
        x = {g, 18'h0, v, 13'h0} & ~(om | (64'h1 << o));
        return x | (64'(h) << o) | (64'(off) & om);
    endfunction
    function automatic pptb_pkg::pptb_result_t hitx(input logic [63:0] p,
        input logic [63:0] va, input int o);
        pptb_pkg::pptb_result_t x;
        logic [39:0] om;
        om = (40'h1 << o) - 40'h1;
        x = '0;
        x.hit = 1'b1;
        x.paddr = ({p[33:6], 12'h000} & ~om) | (va[39:0] & om);
        x.alg = p[5:3];
        x.uncached_attribute = p[63:62];
        return x;
    endfunction
    function automatic logic [63:0] fl(input pptb_pkg::pptb_result_t x);
        return {61'h0, x.hit, x.miss, x.fault};
    endfunction
    initial begin
        logic [30:0] v;
        logic [7:0] t;
        logic [1:0] g;
        int o;
        void'($urandom(88108));
        rst();
        for (int i = 0; i < 14; i++) begin
            o = 12 + 2 * (i % 7);
            g = (i % 3 == 2) ? 2'h3 : 2'(i % 3);
            v = 31'($urandom);
            t = 8'($urandom);
            whi(hi(g, v, t));
            chk64(shi & 64'hff, 64'(t));
            ev = lo(2'($urandom), 28'($urandom), 3'($urandom), 1'b1, 1'b1);
            od = lo(2'($urandom), 28'($urandom), 3'($urandom), 1'b1, 1'b1);
            went(6'($urandom), 12'hfff >> (24 - o));
            a = mkva(g, v, o, 1'b0, 24'($urandom));
            lk(1'b0, a, 1'($urandom));
            chk(r, hitx(ev, a, o));
            b = mkva(g, v, o, 1'b1, 24'($urandom));
            lk(1'b1, b, 1'b0);
            chk(r, hitx(od, b, o));
        end
        // A second reset in mid-run must leave no entry live.
        rst();
        chk64({shi[7:0], 55'h0, flag}, 64'h0);
        a = mkva(2'h0, 31'h1000, 12, 1'b0, 24'habc);
        b = mkva(2'h0, 31'h1000, 12, 1'b1, 24'h123);
        lk(1'b0, a, 1'b0);
        chk64(fl(r), 64'h2);
        whi(hi(2'h0, 31'h1000, 8'h5a));
        ev = lo(2'h1, 28'h1234567, 3'h3, 1'b1, 1'b1);
        od = lo(2'h2, 28'h7654321, 3'h5, 1'b0, 1'b1);
        went(6'h3f, 12'h000);
        lk(1'b0, a, 1'b1);
        chk(r, hitx(ev, a, 12));
        lk(1'b1, b, 1'b0);
        chk(r, hitx(od, b, 12));
        lk(1'b0, b, 1'b1);
        chk64(fl(r), 64'h1);
        lk(1'b0, a | 64'h3fff_f000_0000_0000, 1'b0);
        chk(r, hitx(ev, a, 12));
        lk(1'b0, a | 64'h4000_0000_0000_0000, 1'b0);
        chk64(fl(r), 64'h2);
        whi(hi(2'h0, 31'h3000, 8'ha5));
        lk(1'b0, a, 1'b0);
        chk64(fl(r), 64'h2);
        ev[0] = 1'b1;
        od[0] = 1'b1;
        went(6'h05, 12'h000);
        whi(hi(2'h0, 31'h1000, 8'h11));
        lk(1'b0, mkva(2'h0, 31'h3000, 12, 1'b0, 24'h0), 1'b0);
        chk64(fl(r), 64'h4);
        whi(hi(2'h0, 31'h1000, 8'h5a));
        lk(1'b0, a, 1'b0);
        chk64(fl(r), 64'h4);
        ev[0] = 1'b0;
        od[0] = 1'b0;
        whi(hi(2'h0, 31'h7000, 8'h5a));
        went(6'h14, 12'h000);
        whi(hi(2'h0, 31'h7001, 8'h5a));
        went(6'h15, 12'h000);
        chk64(64'(flag), 64'h0);
        went(6'h16, 12'hfff);
        chk64(64'(flag), 64'h1);
        a = mkva(2'h0, 31'h7001, 12, 1'b0, 24'h456);
        lk(1'b0, a, 1'b0);
        chk(r, hitx(ev, a, 24));
        went(6'h17, 12'h000);
        chk64(64'(flag), 64'h0);
        summarize();
    end
endmodule
